// ==== bstp_pkg.sv ====
// Constants and types shared by the boundary-scan test port
package bstp_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int CHAIN_LEN = 173;
    localparam int IR_W = 4;
    localparam int ID_W = 32;
    localparam int GROUPS = 4;
    localparam int TMS_RESET_COUNT = 5;

    // ------------------------------------------------------------
    // Chain positions of the embedded control cells, counted from 1
    // ------------------------------------------------------------
    localparam int CTRL_POS_A = 26;
    localparam int CTRL_POS_B = 73;
    localparam int CTRL_POS_C = 113;
    localparam int CTRL_POS_D = 153;

    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [IR_W-1:0] INSTR_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] INSTR_SAMPLE = 4'h1;
    localparam logic [IR_W-1:0] INSTR_IDCODE = 4'h2;
    localparam logic [IR_W-1:0] INSTR_BYPASS = 4'hf;

    // Identification value is arbitrary; bit 0 must stay one
    localparam logic [ID_W-1:0] ID_VALUE = 32'h0a5a_5001;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [CHAIN_LEN-1:0] CHAIN_RESET = '1;
    localparam logic [GROUPS-1:0] GROUP_OE_RESET = 4'hf;
    localparam logic [2:0] TMS_CNT_RESET = 3'h0;

    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        TAP_RESET = 16'h0001,
        TAP_IDLE = 16'h0002,
        TAP_SELDR = 16'h0004,
        TAP_CAPDR = 16'h0008,
        TAP_SHDR = 16'h0010,
        TAP_EX1DR = 16'h0020,
        TAP_PSDR = 16'h0040,
        TAP_EX2DR = 16'h0080,
        TAP_UPDR = 16'h0100,
        TAP_SELIR = 16'h0200,
        TAP_CAPIR = 16'h0400,
        TAP_SHIR = 16'h0800,
        TAP_EX1IR = 16'h1000,
        TAP_PSIR = 16'h2000,
        TAP_EX2IR = 16'h4000,
        TAP_UPIR = 16'h8000
    } bstp_tap_t;

endpackage

// ==== bstp_sync.sv ====
// Two-stage synchroniser for levels arriving from outside the clock domain
`timescale 1ns/10ps
module bstp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,           // Core clock
    input wire logic rst_b,              // Synchronous reset, active low
    input wire logic [WIDTH-1:0] asyncIn, // Levels from pins
    output logic [WIDTH-1:0] syncOut     // Levels in the core domain
);

    logic [WIDTH-1:0] stageOne_reg;

    // First stage is read only by the second
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            stageOne_reg <= '0;
            syncOut <= '0;
        end else begin
            stageOne_reg <= asyncIn;
            syncOut <= stageOne_reg;
        end
    end

endmodule

// ==== bstp_chain.sv ====
// Boundary chain: one capture/shift stage and one update stage per cell
`timescale 1ns/10ps
module bstp_chain (
    input wire logic core_clk,                           // Core clock
    input wire logic rst_b,                              // Synchronous reset, active low
    input wire logic captureEn,                          // Parallel capture strobe
    input wire logic shiftEn,                            // Serial shift strobe
    input wire logic updateEn,                           // Update strobe
    input wire logic serialIn,                           // Test data in
    input wire logic [bstp_pkg::CHAIN_LEN-1:0] capData,  // Pin levels to capture
    output logic serialOut,                              // Last cell, toward test data out
    output logic [bstp_pkg::CHAIN_LEN-1:0] updData       // Held update values
);

    logic [bstp_pkg::CHAIN_LEN-1:0] shift_reg;

    // ------------------------------------------------------------
    // Cells; index 0 is position 1, nearest test data in
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < bstp_pkg::CHAIN_LEN; i++) begin : gCell
            logic prevBit;
            if (i == 0) begin : gFirst
                assign prevBit = serialIn;
            end else begin : gRest
                assign prevBit = shift_reg[i-1];
            end
            // Bidirectional pins share one combined cell
            always_ff @(posedge core_clk) begin
                if (!rst_b) begin
                    shift_reg[i] <= bstp_pkg::CHAIN_RESET[i];
                    updData[i] <= bstp_pkg::CHAIN_RESET[i];
                end else begin
                    if (captureEn) begin
                        shift_reg[i] <= capData[i];
                    end else if (shiftEn) begin
                        shift_reg[i] <= prevBit;
                    end
                    if (updateEn) begin
                        updData[i] <= shift_reg[i];
                    end
                end
            end
        end
    endgenerate

    assign serialOut = shift_reg[bstp_pkg::CHAIN_LEN-1];

endmodule

// ==== bstp_top.sv ====
// Boundary-scan test port: controller, instruction, identification, bypass
`timescale 1ns/10ps

// Notes on behaviour
// - Controller moves on test clock rising edges and is held in reset while the port is disabled; starts in reset state.
// - Five rising edges with mode select high reach the reset state.
// - Instruction register is four bits, least significant bit shifts out first.
// - Capture of the instruction register loads the identification instruction.
// - Boundary chain is one serial path through every non-test pin and control cell.
// - Identification register is 32 bits, fixed code, captured and shifted.
// - Bypass gives a one-stage path with one test clock of delay.
// - Sample captures pin states and preloads cells, pins keep normal operation.
// - Extest drives outputs from cells; inputs and driven outputs are captured.
// - Identification instruction puts identification register between data in and out.
// - Chain is exactly 173 cells; tester gives that many shift clocks.
// - Each bidirectional pin has one combined capture and drive cell.
// - Position 1 sits at data in; the last cell sits at data out.
// - Control cells are active low: zero enables the group drivers.
// - Cell 26 governs pins 106 to 155, cell 73 pins 158 to 200.
// - The four shared test pins have no cells in the chain.
// - Enable pin is dedicated; the other four test signals share pins.
// - With enable high, three shared pins act as clock, data in, mode select.
module bstp_top (
    input wire logic core_clk,                             // 100 MHz core clock
    input wire logic rst_b,                                // Synchronous reset, active low
    input wire logic testPortEnable,                       // Dedicated test port enable pin
    input wire logic dmaChanTwoAckPin,                     // Shared pin, test clock
    input wire logic dmaAddrEnablePin,                     // Shared pin, test data in
    input wire logic termCountPin,                         // Shared pin, mode select
    input wire logic [bstp_pkg::CHAIN_LEN-1:0] padIn,      // Pad levels per cell
    input wire logic [bstp_pkg::CHAIN_LEN-1:0] coreOut,    // Functional values per cell
    input wire logic [bstp_pkg::GROUPS-1:0] coreGroupOeB,  // Functional group enables, low
    output logic tdoOut,                                   // Test data out
    output logic tdoOe,                                    // Test data out drive enable
    output logic [bstp_pkg::CHAIN_LEN-1:0] padOut,         // Values toward the pads
    output logic [bstp_pkg::GROUPS-1:0] groupOeB           // Group drive enables, low
);

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    logic [3:0] pinSync;
    logic [bstp_pkg::CHAIN_LEN-1:0] padSync;
    logic enSync;
    logic tckSync;
    logic tdiSync;
    logic tmsSync;
    logic tckPrev_reg;
    logic tckRise;
    logic tckFall;

    // Test pins have no chain cells; only the enable is dedicated
    bstp_sync #(.WIDTH(4)) uPinSync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .asyncIn({testPortEnable, dmaChanTwoAckPin, dmaAddrEnablePin, termCountPin}),
        .syncOut(pinSync)
    );

    bstp_sync #(.WIDTH(bstp_pkg::CHAIN_LEN)) uPadSync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .asyncIn(padIn),
        .syncOut(padSync)
    );

    assign enSync = pinSync[3];
    assign tckSync = pinSync[2];
    assign tdiSync = pinSync[1];
    assign tmsSync = pinSync[0];

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tckPrev_reg <= 1'b0;
        end else begin
            tckPrev_reg <= tckSync;
        end
    end

    // Shared pins count as test signals only while enabled
    assign tckRise = enSync & tckSync & ~tckPrev_reg;
    assign tckFall = enSync & ~tckSync & tckPrev_reg;

    // ------------------------------------------------------------
    // Controller
    // ------------------------------------------------------------
    bstp_pkg::bstp_tap_t state_reg;
    bstp_pkg::bstp_tap_t state_next;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            bstp_pkg::TAP_RESET: state_next = tmsSync ? bstp_pkg::TAP_RESET : bstp_pkg::TAP_IDLE;
            bstp_pkg::TAP_IDLE: state_next = tmsSync ? bstp_pkg::TAP_SELDR : bstp_pkg::TAP_IDLE;
            bstp_pkg::TAP_SELDR: state_next = tmsSync ? bstp_pkg::TAP_SELIR : bstp_pkg::TAP_CAPDR;
            bstp_pkg::TAP_CAPDR: state_next = tmsSync ? bstp_pkg::TAP_EX1DR : bstp_pkg::TAP_SHDR;
            bstp_pkg::TAP_SHDR: state_next = tmsSync ? bstp_pkg::TAP_EX1DR : bstp_pkg::TAP_SHDR;
            bstp_pkg::TAP_EX1DR: state_next = tmsSync ? bstp_pkg::TAP_UPDR : bstp_pkg::TAP_PSDR;
            bstp_pkg::TAP_PSDR: state_next = tmsSync ? bstp_pkg::TAP_EX2DR : bstp_pkg::TAP_PSDR;
            bstp_pkg::TAP_EX2DR: state_next = tmsSync ? bstp_pkg::TAP_UPDR : bstp_pkg::TAP_SHDR;
            bstp_pkg::TAP_UPDR: state_next = tmsSync ? bstp_pkg::TAP_SELDR : bstp_pkg::TAP_IDLE;
            bstp_pkg::TAP_SELIR: state_next = tmsSync ? bstp_pkg::TAP_RESET : bstp_pkg::TAP_CAPIR;
            bstp_pkg::TAP_CAPIR: state_next = tmsSync ? bstp_pkg::TAP_EX1IR : bstp_pkg::TAP_SHIR;
            bstp_pkg::TAP_SHIR: state_next = tmsSync ? bstp_pkg::TAP_EX1IR : bstp_pkg::TAP_SHIR;
            bstp_pkg::TAP_EX1IR: state_next = tmsSync ? bstp_pkg::TAP_UPIR : bstp_pkg::TAP_PSIR;
            bstp_pkg::TAP_PSIR: state_next = tmsSync ? bstp_pkg::TAP_EX2IR : bstp_pkg::TAP_PSIR;
            bstp_pkg::TAP_EX2IR: state_next = tmsSync ? bstp_pkg::TAP_UPIR : bstp_pkg::TAP_SHIR;
            bstp_pkg::TAP_UPIR: state_next = tmsSync ? bstp_pkg::TAP_SELDR : bstp_pkg::TAP_IDLE;
            default: state_next = bstp_pkg::TAP_RESET;
        endcase
    end

    // Disabled port is parked in reset so re-enabling starts clean
    always_ff @(posedge core_clk) begin
        if (!rst_b || !enSync) begin
            state_reg <= bstp_pkg::TAP_RESET;
        end else if (tckRise) begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    logic [bstp_pkg::IR_W-1:0] irShift_reg;
    logic [bstp_pkg::IR_W-1:0] instr_reg;
    logic [bstp_pkg::IR_W-1:0] instr_next;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            irShift_reg <= bstp_pkg::INSTR_IDCODE;
        end else if (tckRise && state_reg == bstp_pkg::TAP_CAPIR) begin
            irShift_reg <= bstp_pkg::INSTR_IDCODE;
        end else if (tckRise && state_reg == bstp_pkg::TAP_SHIR) begin
            irShift_reg <= {tdiSync, irShift_reg[bstp_pkg::IR_W-1:1]};
        end
    end

    // Unknown codes fall back to bypass
    always_comb begin
        unique case (irShift_reg)
            bstp_pkg::INSTR_EXTEST: instr_next = bstp_pkg::INSTR_EXTEST;
            bstp_pkg::INSTR_SAMPLE: instr_next = bstp_pkg::INSTR_SAMPLE;
            bstp_pkg::INSTR_IDCODE: instr_next = bstp_pkg::INSTR_IDCODE;
            default: instr_next = bstp_pkg::INSTR_BYPASS;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b || state_reg == bstp_pkg::TAP_RESET) begin
            instr_reg <= bstp_pkg::INSTR_IDCODE;
        end else if (tckRise && state_reg == bstp_pkg::TAP_UPIR) begin
            instr_reg <= instr_next;
        end
    end

    // ------------------------------------------------------------
    // Identification and bypass stages
    // ------------------------------------------------------------
    logic [bstp_pkg::ID_W-1:0] idShift_reg;
    logic bypass_reg;
    logic capDr;
    logic shDr;

    assign capDr = tckRise && state_reg == bstp_pkg::TAP_CAPDR;
    assign shDr = tckRise && state_reg == bstp_pkg::TAP_SHDR;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            idShift_reg <= bstp_pkg::ID_VALUE;
        end else if (instr_reg == bstp_pkg::INSTR_IDCODE) begin
            if (capDr) begin
                idShift_reg <= bstp_pkg::ID_VALUE;
            end else if (shDr) begin
                idShift_reg <= {tdiSync, idShift_reg[bstp_pkg::ID_W-1:1]};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bypass_reg <= 1'b0;
        end else if (instr_reg == bstp_pkg::INSTR_BYPASS) begin
            if (capDr) begin
                bypass_reg <= 1'b0;
            end else if (shDr) begin
                bypass_reg <= tdiSync;
            end
        end
    end

    // ------------------------------------------------------------
    // Boundary chain
    // ------------------------------------------------------------
    logic chainSel;
    logic chainOut;
    logic [bstp_pkg::CHAIN_LEN-1:0] chainUpd;
    logic [bstp_pkg::GROUPS-1:0] ctrlUpd;
    logic extestOn;

    assign chainSel = instr_reg == bstp_pkg::INSTR_SAMPLE || instr_reg == bstp_pkg::INSTR_EXTEST;
    assign extestOn = instr_reg == bstp_pkg::INSTR_EXTEST;

    bstp_chain uChain (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .captureEn(chainSel && capDr),
        .shiftEn(chainSel && shDr),
        .updateEn(chainSel && tckRise && state_reg == bstp_pkg::TAP_UPDR),
        .serialIn(tdiSync),
        .capData(padSync),
        .serialOut(chainOut),
        .updData(chainUpd)
    );

    assign ctrlUpd = {chainUpd[bstp_pkg::CTRL_POS_D-1], chainUpd[bstp_pkg::CTRL_POS_C-1],
                      chainUpd[bstp_pkg::CTRL_POS_B-1], chainUpd[bstp_pkg::CTRL_POS_A-1]};

    // Only extest takes the pads; sample leaves them functional
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            padOut <= '0;
        end else begin
            padOut <= extestOn ? chainUpd : coreOut;
        end
    end

    // Bit 0 is cell 26 (pins 106-155), bit 1 cell 73 (pins 158-200)
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            groupOeB <= bstp_pkg::GROUP_OE_RESET;
        end else begin
            groupOeB <= extestOn ? ctrlUpd : coreGroupOeB;
        end
    end

    // ------------------------------------------------------------
    // Test data out
    // ------------------------------------------------------------
    logic tdoSel;
    logic inShift;

    always_comb begin
        if (state_reg == bstp_pkg::TAP_SHIR) begin
            tdoSel = irShift_reg[0];
        end else if (instr_reg == bstp_pkg::INSTR_IDCODE) begin
            tdoSel = idShift_reg[0];
        end else if (chainSel) begin
            tdoSel = chainOut;
        end else begin
            tdoSel = bypass_reg;
        end
    end

    assign inShift = state_reg == bstp_pkg::TAP_SHIR || state_reg == bstp_pkg::TAP_SHDR;

    always_ff @(posedge core_clk) begin
        if (!rst_b || !enSync) begin
            tdoOut <= 1'b0;
            tdoOe <= 1'b0;
        end else if (tckFall) begin
            tdoOut <= tdoSel;
            tdoOe <= inShift;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [2:0] tmsCnt_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_b || !enSync) begin
            tmsCnt_reg <= bstp_pkg::TMS_CNT_RESET;
        end else if (tckRise) begin
            tmsCnt_reg <= tmsSync ? ((tmsCnt_reg == 3'h7) ? tmsCnt_reg : tmsCnt_reg + 3'h1) : 3'h0;
        end
    end

    AST_TMS_FIVE: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tckRise && tmsSync && tmsCnt_reg >= 3'(bstp_pkg::TMS_RESET_COUNT - 1))
        |=> state_reg == bstp_pkg::TAP_RESET)
        else $error("Five high mode selects did not reach reset");
    AST_ONE_HOT: assert property (@(posedge core_clk) disable iff (!rst_b)
        $onehot(state_reg))
        else $error("Controller state not one-hot");
    AST_NO_MOVE: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!tckRise && enSync && $past(enSync)) |=> $stable(state_reg))
        else $error("State moved without a test clock rise");
    AST_IR_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tckRise && state_reg == bstp_pkg::TAP_CAPIR) |=> irShift_reg == bstp_pkg::INSTR_IDCODE)
        else $error("Instruction capture did not load identification code");
    AST_IR_SHIFT: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tckRise && state_reg == bstp_pkg::TAP_SHIR)
        |=> irShift_reg == {$past(tdiSync), $past(irShift_reg[3:1])})
        else $error("Instruction shift wrong");
    AST_ID_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_b)
        (capDr && instr_reg == bstp_pkg::INSTR_IDCODE) |=> idShift_reg == bstp_pkg::ID_VALUE)
        else $error("Identification value not captured");
    AST_BYPASS_SEL: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tckRise && state_reg == bstp_pkg::TAP_UPIR && irShift_reg[3:2] != 2'h0)
        |=> instr_reg == bstp_pkg::INSTR_BYPASS)
        else $error("Unassigned code did not select bypass");
    AST_BYPASS_PATH: assert property (@(posedge core_clk) disable iff (!rst_b)
        (shDr && instr_reg == bstp_pkg::INSTR_BYPASS) |=> bypass_reg == $past(tdiSync))
        else $error("Bypass stage did not take data in");
    AST_TDO_SHIFT: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tckFall && !inShift) |=> !tdoOe)
        else $error("Data out enabled outside shift states");
    AST_CTRL_EXTEST: assert property (@(posedge core_clk) disable iff (!rst_b)
        (extestOn && $past(extestOn)) |-> groupOeB == $past(ctrlUpd))
        else $error("Group enables not taken from control cells");
    AST_SAMPLE_PASS: assert property (@(posedge core_clk) disable iff (!rst_b)
        (instr_reg == bstp_pkg::INSTR_SAMPLE) |=> padOut == $past(coreOut))
        else $error("Sample disturbed the pads");

endmodule

// ==== bstp_tester.sv ====
// Behavioural boundary-scan tester that drives the serial test port
`timescale 1ns/10ps
module bstp_tester (
    output logic tck,    // Test clock, still between frames
    output logic tms,    // Mode select
    output logic tdi,    // Test data in
    input wire logic tdo,  // Test data out
    input wire logic tdoEn // Test data out drive enable
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One 125 ns test clock; tdo read just before the rise, after it settled
    // Undriven data out reads inverted, so a missing enable shows as bad data
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #62.5;
        q = tdoEn ? tdo : ~tdo;
        tck = 1'b1;
        #62.5;
        tck = 1'b0;
    endtask
endmodule

// ==== bstp_top_tb.sv ====
// Self-checking bench for the boundary-scan test port
`timescale 1ns/10ps
module bstp_top_tb;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic portEn = 1'b1;
    logic tck, tms, tdi, tdoOut, tdoOe;
    logic [172:0] padIn = {1'b0, {43{4'h9}}};
    logic [172:0] coreOut = {1'b1, {43{4'h3}}};
    logic [3:0] coreGroupOeB = 4'h5;
    logic [172:0] padOut;
    logic [3:0] groupOeB;
    logic [172:0] upd = {1'b1, {43{4'h6}}} ^ (173'h1 << 72);
    logic [172:0] d;
    int fails = 0;
    int comparisons = 0;

    always #5 core_clk = ~core_clk;

    bstp_top u_bstp_top (.core_clk(core_clk), .rst_b(rst_b), .testPortEnable(portEn),
        .dmaChanTwoAckPin(tck), .dmaAddrEnablePin(tdi), .termCountPin(tms),
        .padIn(padIn), .coreOut(coreOut), .coreGroupOeB(coreGroupOeB),
        .tdoOut(tdoOut), .tdoOe(tdoOe), .padOut(padOut), .groupOeB(groupOeB));
    bstp_tester u_bstp_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdoOut), .tdoEn(tdoOe));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [172:0] got, input logic [172:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    function automatic logic [172:0] rev(input logic [172:0] v);
        logic [172:0] r;
        for (int i = 0; i < 173; i++) r[i] = v[172-i];
        return r;
    endfunction

    task automatic nav(input int n, input logic [7:0] seq);
        logic q;
        for (int i = 0; i < n; i++) u_bstp_tester.step(seq[i], 1'b0, q);
    endtask

    // Shift n bits, LSB first, last one leaving the shift state
    task automatic shift(input int n, input logic [172:0] din, output logic [172:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++) u_bstp_tester.step(i == n - 1, din[i], dout[i]);
    endtask

    task automatic loadIr(input logic [3:0] code, output logic [172:0] cap);
        nav(4, 8'h03);
        shift(4, 173'(code), cap);
        nav(2, 8'h01);
    endtask

    task automatic dr(input int n, input logic [172:0] din, output logic [172:0] dout);
        nav(3, 8'h01);
        shift(n, din, dout);
        nav(2, 8'h01);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic testIdcode();
        nav(6, 8'h1f);
        dr(32, '0, d);
        check(d, 173'(bstp_pkg::ID_VALUE), "id value");
        loadIr(bstp_pkg::INSTR_IDCODE, d);
        check(d, 173'(bstp_pkg::INSTR_IDCODE), "ir capture");
        $display("test idcode done");
    endtask

    task automatic testBypass();
        logic [3:0] codes [2] = '{bstp_pkg::INSTR_BYPASS, 4'h5};
        foreach (codes[k]) begin
            loadIr(codes[k], d);
            dr(8, 173'h0b4, d);
            // Eight reads: the captured zero, then the first seven bits in
            check(d, 173'h068, "bypass delay");
        end
        $display("test bypass done");
    endtask

    task automatic testSampleExtest();
        loadIr(bstp_pkg::INSTR_SAMPLE, d);
        dr(173, rev(upd), d);
        check(d, rev(padIn), "sample capture order");
        check(padOut, coreOut, "pins kept under sample");
        loadIr(bstp_pkg::INSTR_EXTEST, d);
        check(padOut, upd, "extest drive");
        check(173'(groupOeB), 173'({upd[152], upd[112], upd[72], upd[25]}),
            "ctrl");
        @(negedge core_clk) padIn = ~padIn;
        dr(173, rev(upd), d);
        check(d, rev(padIn), "extest capture");
        $display("test sample extest done");
    endtask

    task automatic testModeReset();
        nav(3, 8'h01);
        nav(5, 8'h1f);
        nav(1, 8'h00);
        check(padOut, coreOut, "reset leaves extest");
        check(173'(groupOeB), 173'(coreGroupOeB), "group enables");
        check(173'(tdoOe), 173'h0, "tdo idle");
        $display("test mode reset done");
    endtask

    // Port switched off in Shift-DR must park in reset with data out released
    task automatic testDisable();
        loadIr(bstp_pkg::INSTR_BYPASS, d);
        nav(3, 8'h01);
        repeat (5) @(negedge core_clk);
        check(173'(tdoOe), 173'h1, "tdo driven in shift");
        portEn = 1'b0;
        nav(4, 8'h00);
        check(173'({tdoOut, tdoOe}), 173'h0, "port off");
        @(negedge core_clk) portEn = 1'b1;
        repeat (4) @(negedge core_clk);
        nav(1, 8'h00);
        dr(32, '0, d);
        check(d, 173'(bstp_pkg::ID_VALUE), "re-enable from reset");
        $display("test disable done");
    endtask

    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #300000;
        fails++;
        summarize();
    end

    initial begin
        repeat (12) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (5) @(negedge core_clk);
        #2.5;
        check(173'({tdoOut, tdoOe}), 173'h0, "tdo after reset");
        check(padOut, coreOut, "pins follow core");
        testIdcode();
        testBypass();
        testSampleExtest();
        testModeReset();
        testDisable();
        summarize();
    end
endmodule
